/* design/fpc_regs.vh */
// register map, command codes and reset values of the flash controller
`ifndef FPC_REGS_VH
`define FPC_REGS_VH
// ==========================================================
// register byte offsets
`define FPC_OFS_CTRL 8'h00
`define FPC_OFS_PAGE 8'h04
`define FPC_OFS_STAT 8'h08
`define FPC_OFS_PADR 8'h0C
`define FPC_OFS_DATA 8'h10
// ==========================================================
// control register command values
`define FPC_CMD_KEY1 8'h73
`define FPC_CMD_KEY2 8'h8C
`define FPC_CMD_PERASE 8'h95
`define FPC_CMD_MERASE 8'h63
`define FPC_CMD_SPSEL 8'h5E
// ==========================================================
// field positions and fixed values
`define FPC_PAGE_INFO_BIT 7
`define FPC_OPT_WP_BIT 7
`define FPC_OPT_BSP_BIT 6
`define FPC_INFO_BASE 16'hFE00
`define FPC_INFO_LAST 16'hFE7F
`define FPC_PAGE_BITS 9
`define FPC_NUM_SECT 8
`define FPC_ERASED 8'hFF
`define FPC_RST_PAGE 8'h00
`define FPC_RST_PROT 8'h00
`define FPC_RST_PADR 16'h0000
`endif

/* design/fpc_top.v */
// flash program and erase controller with wishbone register port
`timescale 1ns/100ps
`default_nettype none
`include "fpc_regs.vh"

module fpc_top #(
   parameter AW = 13,
   parameter OPT_ADDR = 13'h0000
) (
   // system
   input wire clk_sys,
   input wire rst_n,
   // wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // system status
   input wire dbg_access,
   input wire stop_recover,
   output reg core_stall_reg,
   output reg [7:0] opt_cfg_reg,
   // bypass pins
   input wire byp_en,
   input wire [AW-1:0] byp_addr,
   input wire [7:0] byp_wdata,
   input wire byp_info,
   input wire byp_prog,
   input wire byp_perase,
   input wire byp_merase,
   // flash array
   input wire [7:0] fl_rdata,
   input wire fl_done,
   output reg [AW-1:0] fl_addr_reg,
   output reg [7:0] fl_wdata_reg,
   output reg fl_info_reg,
   output reg fl_rd_reg,
   output reg fl_prog_reg,
   output reg fl_perase_reg,
   output reg fl_merase_reg
);

   // ==========================================================
   // sizes and states
   localparam PW = AW - `FPC_PAGE_BITS;
   localparam SSH = (PW > 3) ? (PW - 3) : 0;
   localparam [2:0] ST_OPT = 3'h0;
   localparam [2:0] ST_OPTW = 3'h1;
   localparam [2:0] ST_LOCK = 3'h2;
   localparam [2:0] ST_PAGE = 3'h3;
   localparam [2:0] ST_KEY1 = 3'h4;
   localparam [2:0] ST_KEY2 = 3'h5;
   localparam [2:0] ST_UNLK = 3'h6;
   localparam [2:0] ST_ERASE = 3'h7;

   // ==========================================================
   // state
   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [7:0] page_reg;
   reg [7:0] page_next;
   reg [7:0] key_page_reg;
   reg [7:0] key_page_next;
   reg [7:0] prot_reg;
   reg [7:0] prot_next;
   reg sp_sel_reg;
   reg sp_sel_next;
   reg [15:0] padr_reg;
   reg [15:0] padr_next;
   reg [7:0] opt_next;
   reg go_prog;
   reg go_perase;
   reg go_merase;
   reg fl_rd_next;

   // ==========================================================
   // helpers
   // sector number of a page; a page never spans two sectors
   function [2:0] sect_of;
      input [PW-1:0] pg;
      reg [PW-1:0] t;
      begin
         t = pg >> SSH;
         sect_of = t[2:0];
      end
   endfunction

   // write permission of a page from options, debug and sector bits
   function wr_ok;
      input [PW-1:0] pg;
      input [7:0] opt;
      input [7:0] prot;
      input dbg;
      reg [2:0] s;
      reg code_ok;
      begin
         s = sect_of(pg);
         // boot protect alone guards only sector zero
         code_ok = opt[`FPC_OPT_WP_BIT] | dbg
            | (opt[`FPC_OPT_BSP_BIT] & (s != 3'h0));
         wr_ok = code_ok & ~prot[s];
      end
   endfunction

   // ==========================================================
   // bus decode
   wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr = req & wb_we_i & wb_sel_i[0];
   wire [7:0] wd = wb_dat_i[7:0];
   wire wr_ctrl = wr & (wb_adr_i == `FPC_OFS_CTRL);
   wire wr_page = wr & (wb_adr_i == `FPC_OFS_PAGE);
   wire wr_padr = wr & (wb_adr_i == `FPC_OFS_PADR);
   wire wr_data = wr & (wb_adr_i == `FPC_OFS_DATA);
   wire info_mode = page_reg[`FPC_PAGE_INFO_BIT];
   wire [PW-1:0] act_page = page_reg[PW-1:0];
   wire page_ok = wr_ok(act_page, opt_cfg_reg, prot_reg, dbg_access);
   wire in_info = (padr_reg >= `FPC_INFO_BASE) && (padr_reg <= `FPC_INFO_LAST);
   wire in_page = (padr_reg[15:`FPC_PAGE_BITS] == {{(16-AW){1'b0}}, act_page});
   // info area is mapped only while the info bit is set
   wire padr_hit = info_mode ? in_info : in_page;
   wire busy = (state_reg == ST_ERASE) | (state_reg == ST_OPT)
      | (state_reg == ST_OPTW);

   // ==========================================================
   // next-state logic of the unlock sequencer
   always @*
   begin
      state_next = state_reg;
      page_next = page_reg;
      key_page_next = key_page_reg;
      prot_next = prot_reg;
      sp_sel_next = sp_sel_reg;
      padr_next = padr_reg;
      opt_next = opt_cfg_reg;
      go_prog = 1'b0;
      go_perase = 1'b0;
      go_merase = 1'b0;
      fl_rd_next = 1'b0;
      if (wr_padr)
      begin
         padr_next = wb_dat_i[15:0];
      end
      // any control value written while not busy clears the protect-register mapping except 5EH
      if (wr_ctrl && !busy)
      begin
         sp_sel_next = (wd == `FPC_CMD_SPSEL);
      end
      // protect bits may only be set from software
      if (wr_page && sp_sel_reg && !busy)
      begin
         prot_next = prot_reg | wd;
      end
      else if (wr_page && !busy)
      begin
         page_next = wd;
      end
      case (state_reg)
         ST_OPT:
         begin
            fl_rd_next = 1'b1;
            state_next = ST_OPTW;
         end
         ST_OPTW:
         begin
            // option byte is held outside the register file
            opt_next = fl_rdata;
            state_next = ST_LOCK;
         end
         ST_LOCK:
         begin
            if (wr_page && !sp_sel_reg)
            begin
               key_page_next = wd;
               state_next = ST_PAGE;
            end
         end
         ST_PAGE:
         begin
            if (wr_ctrl)
            begin
               state_next = (wd == `FPC_CMD_KEY1) ? ST_KEY1 : ST_LOCK;
            end
            else if (wr_page && !sp_sel_reg)
            begin
               key_page_next = wd;
            end
         end
         ST_KEY1:
         begin
            if (wr_ctrl)
            begin
               state_next = (wd == `FPC_CMD_KEY2) ? ST_KEY2 : ST_LOCK;
            end
            else if (wr_page)
            begin
               state_next = ST_LOCK;
            end
         end
         ST_KEY2:
         begin
            if (wr_ctrl)
            begin
               state_next = ST_LOCK;
            end
            else if (wr_page && !sp_sel_reg)
            begin
               // both page writes must agree
               state_next = (wd == key_page_reg) ? ST_UNLK : ST_LOCK;
            end
         end
         ST_UNLK:
         begin
            if (wr_ctrl)
            begin
               // every control write ends the unlocked window
               state_next = ST_LOCK;
               if (wd == `FPC_CMD_PERASE && page_ok)
               begin
                  go_perase = 1'b1;
                  state_next = ST_ERASE;
               end
               // mass erase only through the debugger
               else if (wd == `FPC_CMD_MERASE && dbg_access && prot_reg == 8'h00)
               begin
                  go_merase = 1'b1;
                  state_next = ST_ERASE;
               end
            end
            else if (wr_page && !sp_sel_reg && wd != page_reg)
            begin
               state_next = ST_LOCK;
            end
            else if (wr_data && padr_hit && page_ok)
            begin
               // the page stays open for further bytes
               go_prog = 1'b1;
            end
         end
         ST_ERASE:
         begin
            if (fl_done)
            begin
               state_next = ST_LOCK;
            end
         end
         default:
         begin
            state_next = ST_LOCK;
         end
      endcase
      // stop recovery reloads options and relocks
      if (stop_recover)
      begin
         state_next = ST_OPT;
         go_prog = 1'b0;
         go_perase = 1'b0;
         go_merase = 1'b0;
      end
   end

   // ==========================================================
   // sequencer registers; reset always lands in the option load
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         state_reg <= ST_OPT;
         page_reg <= `FPC_RST_PAGE;
         key_page_reg <= `FPC_RST_PAGE;
         prot_reg <= `FPC_RST_PROT;
         sp_sel_reg <= 1'b0;
         padr_reg <= `FPC_RST_PADR;
         opt_cfg_reg <= 8'h00;
         core_stall_reg <= 1'b1;
      end
      else
      begin
         state_reg <= state_next;
         page_reg <= page_next;
         key_page_reg <= key_page_next;
         prot_reg <= prot_next;
         sp_sel_reg <= sp_sel_next;
         padr_reg <= padr_next;
         opt_cfg_reg <= opt_next;
         // core idles through option load and erases only
         core_stall_reg <= (state_next == ST_ERASE) | (state_next == ST_OPT)
            | (state_next == ST_OPTW);
      end
   end

   // ==========================================================
   // flash array drive; bypass pins take over the array outright
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         fl_addr_reg <= {AW{1'b0}};
         fl_wdata_reg <= 8'h00;
         fl_info_reg <= 1'b0;
         fl_rd_reg <= 1'b0;
         fl_prog_reg <= 1'b0;
         fl_perase_reg <= 1'b0;
         fl_merase_reg <= 1'b0;
      end
      else if (byp_en)
      begin
         fl_addr_reg <= byp_addr;
         fl_wdata_reg <= byp_wdata;
         fl_info_reg <= byp_info;
         fl_rd_reg <= 1'b0;
         fl_prog_reg <= byp_prog;
         fl_perase_reg <= byp_perase;
         fl_merase_reg <= byp_merase;
      end
      else
      begin
         fl_rd_reg <= fl_rd_next;
         fl_prog_reg <= go_prog;
         fl_perase_reg <= go_perase;
         fl_merase_reg <= go_merase;
         if (fl_rd_next)
         begin
            fl_addr_reg <= OPT_ADDR;
            fl_info_reg <= 1'b0;
         end
         else if (go_prog)
         begin
            fl_addr_reg <= padr_reg[AW-1:0];
            fl_info_reg <= info_mode;
            fl_wdata_reg <= wd;
         end
         else if (go_perase)
         begin
            // erase hits one whole page, byte offset zero
            fl_addr_reg <= {act_page, {`FPC_PAGE_BITS{1'b0}}};
            fl_info_reg <= info_mode;
         end
      end
   end

   // ==========================================================
   // wishbone answer: one wait state, unmapped reads return zero
   always @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= req;
         if (req && !wb_we_i)
         begin
            case (wb_adr_i)
               `FPC_OFS_CTRL: wb_dat_o <= {29'h00000000, state_reg};
               `FPC_OFS_PAGE: wb_dat_o <= {24'h000000, sp_sel_reg ? prot_reg : page_reg};
               `FPC_OFS_STAT: wb_dat_o <= {26'h0000000, byp_en, busy, sp_sel_reg,
                  state_reg};
               `FPC_OFS_PADR: wb_dat_o <= {16'h0000, padr_reg};
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

endmodule
`default_nettype wire

/* test/fpc_properties.sv */
// port assertions for the flash program and erase controller
`timescale 1ns/100ps
`default_nettype none
`include "fpc_regs.vh"
module fpc_props #(
   parameter AW = 13,
   parameter OPT_ADDR = 13'h0000
) (
   // system and bus
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic dbg_access,
   input wire logic byp_en,
   input wire logic [AW-1:0] byp_addr,
   input wire logic byp_perase,
   // flash side
   input wire logic core_stall_reg,
   input wire logic fl_done,
   input wire logic [AW-1:0] fl_addr_reg,
   input wire logic fl_rd_reg,
   input wire logic fl_prog_reg,
   input wire logic fl_perase_reg,
   input wire logic fl_merase_reg
);
   // ==========================================
   // controller strobes with bypass excluded; AST_BYP_PASS checks the bypass pin copies
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire own = !byp_en;
   AST_RST_STALL: assert property ($rose(rst_n) |-> core_stall_reg)
      else $error("core not held after reset");
   AST_OPT_LOAD: assert property ($rose(rst_n) |=> fl_rd_reg && fl_addr_reg == OPT_ADDR)
      else $error("option byte not read after reset");
   AST_RST_LOCK: assert property ($rose(rst_n) && own |->
      (!fl_prog_reg && !fl_perase_reg && !fl_merase_reg) [*4])
      else $error("flash strobe right after reset");
   AST_ERASE_STALL: assert property ((fl_perase_reg || fl_merase_reg) && own
      && $past(own) |-> core_stall_reg)
      else $error("erase without core stall");
   AST_DONE_FREE: assert property (core_stall_reg && fl_done |-> ##[1:2] !core_stall_reg)
      else $error("stall kept after erase done");
   AST_PAGE_ALIGN: assert property (fl_perase_reg && own && $past(own)
      |-> fl_addr_reg[8:0] == 9'h000)
      else $error("page erase address not page aligned");
   AST_PROG_CAUSE: assert property (fl_prog_reg && own && $past(own)
      |-> $past(wb_we_i) && $past(wb_adr_i) == `FPC_OFS_DATA)
      else $error("program strobe without data write");
   AST_MASS_DBG: assert property (fl_merase_reg && own && $past(own)
      |-> $past(dbg_access))
      else $error("mass erase outside debug access");
   AST_BYP_PASS: assert property (byp_en |=> fl_addr_reg == $past(byp_addr)
      && fl_perase_reg == $past(byp_perase))
      else $error("bypass pins not passed to array");
endmodule
bind fpc_top fpc_props #(.AW(AW), .OPT_ADDR(OPT_ADDR)) u_props (.clk_sys, .rst_n, .wb_we_i,
   .wb_adr_i, .dbg_access, .byp_en, .byp_addr, .byp_perase, .core_stall_reg, .fl_done,
   .fl_addr_reg, .fl_rd_reg, .fl_prog_reg, .fl_perase_reg, .fl_merase_reg);
`default_nettype wire

/* test/fpc_flash_model.sv */
// flash array stand-in: option byte read and timed erase completion
`timescale 1ns/100ps
`default_nettype none
module fpc_flash_model #(
   parameter int DLY = 8
) (
   // clock and array strobes
   input wire logic clk_sys,
   input wire logic fl_rd_reg,
   input wire logic fl_perase_reg,
   input wire logic fl_merase_reg,
   input wire logic [7:0] opt_val,
   // array answers
   output logic [7:0] fl_rdata,
   output logic fl_done
);
   // ==========================================
   logic [7:0] junk = 8'h5A;
   logic rd_d = 1'b0;
   int cnt = 0;
   // outside a read and the cycle after it the data toggles, so a capture more than one cycle late cannot pass by luck
   assign fl_rdata = (fl_rd_reg | rd_d) ? opt_val : junk;
   // an erase ends DLY+1 cycles after its strobe rises, with a one-cycle done pulse
   always @(posedge clk_sys)
   begin
      junk <= ~junk;
      rd_d <= fl_rd_reg;
      fl_done <= (cnt == 1);
      if (fl_perase_reg | fl_merase_reg)
         cnt <= DLY;
      else if (cnt != 0)
         cnt <= cnt - 1;
   end
endmodule
`default_nettype wire

/* test/tb_top.sv */
// self-checking bench for the flash program and erase controller
`timescale 1ns/100ps
`default_nettype none
`include "fpc_regs.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
   $display("ERROR %0t got %h want %h", $time, a, b); end end
module tb_top;
   // ==========================================
   // stimulus and observed signals
   logic clk_sys = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [7:0] wb_adr_i = 8'h00, byp_wdata = 8'h00, opt_val = 8'h80;
   logic [7:0] opt_cfg_reg, fl_rdata, fl_wdata_reg;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
   logic wb_ack_o, core_stall_reg, fl_done, fl_info_reg, fl_rd_reg, fl_prog_reg;
   logic fl_perase_reg, fl_merase_reg;
   logic dbg_access = 0, stop_recover = 0, byp_en = 0, byp_info = 0, byp_prog = 0;
   logic byp_perase = 0, byp_merase = 0;
   logic [12:0] byp_addr = 13'h0, fl_addr_reg;
   int miscompares = 0, n_checks = 0, np = 0, ne = 0, nm = 0;
   fpc_top #(.AW(13)) DUT (.clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .dbg_access, .stop_recover, .core_stall_reg,
      .opt_cfg_reg, .byp_en, .byp_addr, .byp_wdata, .byp_info, .byp_prog, .byp_perase,
      .byp_merase, .fl_rdata, .fl_done, .fl_addr_reg, .fl_wdata_reg, .fl_info_reg, .fl_rd_reg,
      .fl_prog_reg, .fl_perase_reg, .fl_merase_reg);
   fpc_flash_model fm (.clk_sys, .fl_rd_reg, .fl_perase_reg, .fl_merase_reg, .opt_val,
      .fl_rdata, .fl_done);
   // clock and strobe counters
   always #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      np <= np + int'(fl_prog_reg === 1'b1);
      ne <= ne + int'(fl_perase_reg === 1'b1);
      nm <= nm + int'(fl_merase_reg === 1'b1);
   end
   // one classic cycle; waits for ack, no latency is assumed
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      i = 0;
      wb_cyc_i <= 1;
      wb_stb_i <= 1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do
      begin
         @(posedge clk_sys);
         i++;
      end
      while (wb_ack_o !== 1'b1 && i < 40);
      // a missing answer counts against the run
      if (wb_ack_o !== 1'b1)
      begin
         miscompares++;
         $display("ERROR %0t no bus ack", $time);
      end
      rdat = wb_dat_o;
      wb_cyc_i <= 0;
      wb_stb_i <= 0;
      @(posedge clk_sys);
   endtask
   task automatic st(input logic [2:0] e);
      wb(0, `FPC_OFS_STAT, 0);
      `CHK(rdat[2:0], e)
   endtask
   task automatic ul(input logic [7:0] p);
      wb(1, `FPC_OFS_PAGE, p);
      wb(1, `FPC_OFS_CTRL, `FPC_CMD_KEY1);
      wb(1, `FPC_OFS_CTRL, `FPC_CMD_KEY2);
      wb(1, `FPC_OFS_PAGE, p);
   endtask
   task automatic pgm(input logic [15:0] a, input logic [7:0] d);
      wb(1, `FPC_OFS_PADR, a);
      wb(1, `FPC_OFS_DATA, d);
      repeat (2) @(posedge clk_sys);
   endtask
   task automatic cmd(input logic [7:0] c);
      wb(1, `FPC_OFS_CTRL, c);
      repeat (2) @(posedge clk_sys);
   endtask
   // the host polls busy until the erase is over
   task automatic idle;
      int i;
      i = 0;
      do
      begin
         wb(0, `FPC_OFS_STAT, 0);
         i++;
      end
      while (rdat[4] !== 1'b0 && i < 40);
      `CHK(rdat[4], 1'b0)
   endtask
   // ==========================================
   // scenarios
   task automatic t_boot;
      repeat (4) @(posedge clk_sys);
      `CHK(opt_cfg_reg, 8'h80)
      st(3'd2);
      wb(0, 8'h14, 0);
      `CHK(rdat, 32'h0)
      pgm(16'h0205, 8'hA5);
      `CHK(np, 0)
   endtask
   task automatic t_prog;
      ul(8'h01);
      st(3'd6);
      pgm(16'h0205, 8'hA5);
      `CHK(np, 1)
      `CHK(fl_addr_reg, 13'h0205)
      `CHK(fl_wdata_reg, 8'hA5)
      // info area closed without bit 7, other pages closed too
      pgm(16'hFE05, 8'h11);
      `CHK(np, 1)
      pgm(16'h0405, 8'h11);
      `CHK(np, 1)
      pgm(16'h03FF, 8'h3C);
      `CHK(np, 2)
      st(3'd6);
      cmd(`FPC_CMD_PERASE);
      `CHK(ne, 1)
      `CHK(fl_addr_reg, 13'h0200)
      `CHK(core_stall_reg, 1'b1)
      idle;
      st(3'd2);
   endtask
   task automatic t_relock;
      ul(8'h01);
      cmd(8'h11);
      st(3'd2);
      wb(1, `FPC_OFS_PAGE, 1);
      cmd(`FPC_CMD_KEY1);
      cmd(`FPC_CMD_KEY2);
      wb(1, `FPC_OFS_PAGE, 2);
      st(3'd2);
      ul(8'h01);
      cmd(`FPC_CMD_MERASE);
      `CHK(nm, 0)
      ul(8'h80);
      pgm(16'hFE05, 8'h5A);
      `CHK(np, 3)
      `CHK(fl_info_reg, 1'b1)
      `CHK(fl_addr_reg, 13'h1E05)
      cmd(8'h00);
   endtask
   task automatic t_sector;
      cmd(`FPC_CMD_SPSEL);
      wb(0, `FPC_OFS_STAT, 0);
      `CHK(rdat[3], 1'b1)
      wb(1, `FPC_OFS_PAGE, 32'h02);
      wb(1, `FPC_OFS_PAGE, 32'h00);
      wb(0, `FPC_OFS_PAGE, 0);
      `CHK(rdat[7:0], 8'h02)
      cmd(8'h00);
      ul(8'h02);
      cmd(`FPC_CMD_PERASE);
      `CHK(ne, 1)
      byp_en <= 1;
      byp_addr <= 13'h0ABC;
      byp_perase <= 1;
      byp_prog <= 1;
      @(posedge clk_sys);
      byp_perase <= 0;
      byp_prog <= 0;
      repeat (2) @(posedge clk_sys);
      `CHK(ne, 2)
      `CHK(np, 4)
      `CHK(fl_addr_reg, 13'h0ABC)
      byp_en <= 0;
      repeat (12) @(posedge clk_sys);
   endtask
   task automatic t_opt;
      opt_val <= 8'h00;
      stop_recover <= 1;
      @(posedge clk_sys);
      stop_recover <= 0;
      repeat (4) @(posedge clk_sys);
      `CHK(opt_cfg_reg, 8'h00)
      ul(8'h01);
      cmd(`FPC_CMD_PERASE);
      `CHK(ne, 2)
      // boot protect alone: sector zero closed, sector one open
      opt_val <= 8'h40;
      rst_n <= 0;
      repeat (5) @(posedge clk_sys);
      rst_n <= 1;
      repeat (4) @(posedge clk_sys);
      `CHK(opt_cfg_reg, 8'h40)
      cmd(`FPC_CMD_SPSEL);
      wb(0, `FPC_OFS_PAGE, 0);
      `CHK(rdat[7:0], 8'h00)
      cmd(8'h00);
      ul(8'h01);
      cmd(`FPC_CMD_PERASE);
      `CHK(ne, 2)
      ul(8'h02);
      cmd(`FPC_CMD_PERASE);
      idle;
      `CHK(ne, 3)
      dbg_access <= 1;
      ul(8'h01);
      cmd(`FPC_CMD_PERASE);
      idle;
      `CHK(ne, 4)
      ul(8'h01);
      cmd(`FPC_CMD_MERASE);
      `CHK(nm, 1)
      idle;
      st(3'd2);
   endtask
   task wrap_up;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // main sequence and watchdog
   initial
   begin
      repeat (5) @(posedge clk_sys);
      rst_n <= 1;
      t_boot;
      t_prog;
      t_relock;
      t_sector;
      t_opt;
      wrap_up;
   end
   initial
   begin
      repeat (4000) @(posedge clk_sys);
      miscompares++;
      wrap_up;
   end
endmodule
`default_nettype wire
